// ### core/emx_eeprom_slave.sv
// two-wire serial slave of the data eeprom
//
// Functional notes
// - data stays steady while clock high; changes there are start or stop.
// - both lines high means idle; slave then pulls nothing low.
// - data falling with clock high is start; decoding restarts.
// - data rising with clock high is stop; transfer ends, back to idle.
// - data changes with clock low; one bit per clock high pulse.
// - slave acknowledges each byte received while addressed, on ninth clock.
// - no acknowledge at all while a programming cycle runs.
// - acknowledge pulled low before and through the whole clock high.
// - master not acknowledging ends a read; slave releases data.
// - direction bit one in the control byte selects read.
// - word pointer holds last location plus one for current reads.
// - addressed for read, slave acknowledges then sends one byte.
// - word address write then repeated start keeps the pointer loaded.
// - after a random read pointer sits past the word delivered.
// - master acknowledge during read requests the next word.
// - pointer steps by one at the end of every read byte.
`timescale 1ns/10ps
`default_nettype none
module emx_eeprom_slave (
  // reference clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // two-wire link: clock line is its own domain
  input  wire logic scl_clk_in,
  input  wire logic sda_in,
  output logic      sda_dout_out,
  output logic      sda_oe_out,
  // device side
  input  wire logic prog_busy_in,
  output logic      bus_busy_out,
  output logic      stop_pulse_out,
  output logic      wr_pulse_out
);

  // ---------------- reference domain ----------------
  emx_pkg::emx_line_s line_raw;
  emx_pkg::emx_line_s line_s;
  logic               link_idle;
  logic               prog_busy_ff;
  logic               init_req_ff;
  logic [1:0]         back_s;
  logic               wr_seen_ff;
  logic               wr_pulse_ff;

  assign line_raw = {scl_clk_in, sda_in};

  emx_sync #(
    .W (2)
  ) u_line_sync (
    .clk_in (ref_clk_in),
    .d_in   (line_raw),
    .q_out  (line_s)
  );

  // stop and idle tracking
  emx_cond_det u_cond (
    .ref_clk_in     (ref_clk_in),
    .rst_n_in       (rst_n_in),
    .line_in        (line_s),
    .link_idle_out  (link_idle),
    .stop_pulse_out (stop_pulse_out)
  );

  assign bus_busy_out = ~link_idle;

  // launch flop so only a clean level crosses
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prog_busy_ff <= 1'h0;
    end else begin
      prog_busy_ff <= prog_busy_in;
    end
  end

  // pointer init request, held until the link side answers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      init_req_ff <= 1'h1;
    end else if (back_s[0]) begin
      init_req_ff <= 1'h0;
    end
  end

  // write event arrives as a toggle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wr_seen_ff  <= 1'h0;
      wr_pulse_ff <= 1'h0;
    end else begin
      wr_seen_ff  <= back_s[1];
      wr_pulse_ff <= back_s[1] ^ wr_seen_ff;
    end
  end

  assign wr_pulse_out = wr_pulse_ff;

  // ---------------- link domain ----------------
  emx_pkg::emx_state_e         state_ff;
  emx_pkg::emx_phase_e         phase_ff;
  logic [2:0]                  bit_cnt_ff;
  logic [emx_pkg::BYTE_W-1:0]  sh_ff;
  logic [emx_pkg::BYTE_W-1:0]  tx_ff;
  logic [emx_pkg::MEM_AW-1:0]  ptr_ff;
  logic [emx_pkg::BYTE_W-1:0]  mem_ff [emx_pkg::MEM_DEPTH];
  logic                        samp_ff;
  logic                        drv_ff;
  logic                        rw_ff;
  logic                        wr_tgl_ff;
  logic                        init_ack_ff;
  logic [1:0]                  fwd_s;
  logic                        busy_s;
  logic                        init_s;
  logic                        cond_start;
  logic                        cond_stop;
  logic                        cond_any;
  logic                        rx_state;
  logic                        byte_done;
  logic [emx_pkg::BYTE_W-1:0]  rx_byte;
  logic                        rx_ok;
  logic                        ld_tx;
  logic                        rd_done;
  logic                        wr_en;
  logic [emx_pkg::BYTE_W-1:0]  mem_rd;

  emx_sync #(
    .W (2)
  ) u_fwd_sync (
    .clk_in (scl_clk_in),
    .d_in   ({init_req_ff, prog_busy_ff}),
    .q_out  (fwd_s)
  );

  emx_sync #(
    .W (2)
  ) u_back_sync (
    .clk_in (ref_clk_in),
    .d_in   ({wr_tgl_ff, init_ack_ff}),
    .q_out  (back_s)
  );

  assign busy_s = fwd_s[0];
  assign init_s = fwd_s[1];

  always_ff @(posedge scl_clk_in) begin
    samp_ff <= sda_in;
  end

  // bits commit on the fall: a level change inside the high phase
  // is a condition, not data. link_idle is quasi-static here: it
  // only moves while the clock line holds still or long after a fall.
  // no state term: link flops are unknown until the first start, so
  // idle alone arms it; idle must clear before the next clock fall
  // start and stop detect
  assign cond_start = ~sda_in & (samp_ff | link_idle);
  assign cond_stop  = ~link_idle & ~samp_ff & sda_in;
  assign cond_any   = cond_start | cond_stop;

  assign rx_state  = (state_ff == emx_pkg::ST_ADDR) |
                     (state_ff == emx_pkg::ST_WADDR) |
                     (state_ff == emx_pkg::ST_WDATA);
  assign byte_done = rx_state & ~cond_any &
                     (bit_cnt_ff == emx_pkg::BIT_LAST);
  assign rx_byte   = {sh_ff[emx_pkg::MSB-1:0], samp_ff};
  assign rx_ok     = ~busy_s & ((state_ff != emx_pkg::ST_ADDR) |
                     (rx_byte[emx_pkg::MSB:1] == emx_pkg::DEV_ADDR));
  assign ld_tx     = ~cond_any & (((state_ff == emx_pkg::ST_ACK) &
                     (rw_ff == emx_pkg::RW_READ)) |
                     ((state_ff == emx_pkg::ST_RACK) &
                     (samp_ff == emx_pkg::ACK_LVL)));
  assign rd_done   = ~cond_any & (state_ff == emx_pkg::ST_RDATA) &
                     (bit_cnt_ff == emx_pkg::BIT_LAST);
  assign wr_en     = byte_done & rx_ok &
                     (state_ff == emx_pkg::ST_WDATA);
  assign mem_rd    = mem_ff[ptr_ff];

  // protocol sequencer and line drive
  always_ff @(negedge scl_clk_in) begin
    if (cond_start) begin
      state_ff <= emx_pkg::ST_ADDR;
      drv_ff   <= 1'h0;
    end else if (cond_stop) begin
      state_ff <= emx_pkg::ST_IDLE;
      drv_ff   <= 1'h0;
    end else begin
      unique case (state_ff)
        emx_pkg::ST_IDLE: begin
          drv_ff <= 1'h0;
        end
        emx_pkg::ST_ADDR, emx_pkg::ST_WADDR, emx_pkg::ST_WDATA: begin
          if (byte_done) begin
            state_ff <= rx_ok ? emx_pkg::ST_ACK : emx_pkg::ST_IDLE;
            drv_ff   <= rx_ok;
          end
        end
        emx_pkg::ST_ACK: begin
          if (rw_ff == emx_pkg::RW_READ) begin
            state_ff <= emx_pkg::ST_RDATA;
            drv_ff   <= ~mem_rd[emx_pkg::MSB];
          end else begin
            state_ff <= (phase_ff == emx_pkg::PH_WADDR) ?
                        emx_pkg::ST_WADDR : emx_pkg::ST_WDATA;
            drv_ff   <= 1'h0;
          end
        end
        emx_pkg::ST_RDATA: begin
          if (rd_done) begin
            state_ff <= emx_pkg::ST_RACK;
            drv_ff   <= 1'h0;
          end else begin
            drv_ff   <= ~tx_ff[emx_pkg::MSB-1];
          end
        end
        emx_pkg::ST_RACK: begin
          if (samp_ff == emx_pkg::ACK_LVL) begin
            state_ff <= emx_pkg::ST_RDATA;
            drv_ff   <= ~mem_rd[emx_pkg::MSB];
          end else begin
            state_ff <= emx_pkg::ST_IDLE;
            drv_ff   <= 1'h0;
          end
        end
        default: begin
          state_ff <= emx_pkg::ST_IDLE;
          drv_ff   <= 1'h0;
        end
      endcase
    end
  end

  always_ff @(negedge scl_clk_in) begin
    if (cond_start) begin
      bit_cnt_ff <= emx_pkg::BIT_FIRST;
    end else if (rx_state | (state_ff == emx_pkg::ST_RDATA)) begin
      bit_cnt_ff <= bit_cnt_ff + emx_pkg::BIT_STEP;
    end else begin
      bit_cnt_ff <= emx_pkg::BIT_FIRST;
    end
  end

  always_ff @(negedge scl_clk_in) begin
    if (rx_state & ~cond_any) begin
      sh_ff <= rx_byte;
    end
  end

  always_ff @(negedge scl_clk_in) begin
    if (ld_tx) begin
      tx_ff <= mem_rd;
    end else if ((state_ff == emx_pkg::ST_RDATA) & ~cond_any) begin
      tx_ff <= {tx_ff[emx_pkg::MSB-1:0], 1'h0};
    end
  end

  // control byte direction and write phase
  always_ff @(negedge scl_clk_in) begin
    if (byte_done & rx_ok & (state_ff == emx_pkg::ST_ADDR)) begin
      rw_ff    <= samp_ff;
      phase_ff <= emx_pkg::PH_WADDR;
    end else if (byte_done & rx_ok & (state_ff == emx_pkg::ST_WADDR)) begin
      phase_ff <= emx_pkg::PH_WDATA;
    end
  end

  always_ff @(negedge scl_clk_in) begin
    init_ack_ff <= init_s;
    if (init_s) begin
      ptr_ff <= emx_pkg::PTR_INIT;
    end else if (byte_done & rx_ok & (state_ff == emx_pkg::ST_WADDR)) begin
      ptr_ff <= rx_byte[emx_pkg::MEM_AW-1:0];
    end else if (rd_done | wr_en) begin
      ptr_ff <= ptr_ff + emx_pkg::PTR_STEP;
    end
  end

  // array write, event handed to the reference side
  always_ff @(negedge scl_clk_in) begin
    if (wr_en) begin
      mem_ff[ptr_ff] <= rx_byte;
      wr_tgl_ff      <= ~wr_tgl_ff;
    end else if (init_s) begin
      wr_tgl_ff      <= 1'h0;
    end
  end

  // open drain: only ever pull low
  assign sda_dout_out = 1'h0;
  assign sda_oe_out   = drv_ff & ~link_idle;

  // ---------------- checks ----------------
  property p_idle_release;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      link_idle |-> !sda_oe_out;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("slave pulls data low on an idle bus");

  property p_stop_idle;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      stop_pulse_out |-> link_idle && !bus_busy_out;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return the bus to idle");

  property p_start_restart;
    @(negedge scl_clk_in) disable iff (init_s)
      cond_start |=> state_ff == emx_pkg::ST_ADDR &&
                     bit_cnt_ff == emx_pkg::BIT_FIRST && !drv_ff;
  endproperty
  a_start_restart: assert property (p_start_restart)
    else $error("start did not restart decoding");

  property p_ack_drive;
    @(negedge scl_clk_in) disable iff (init_s)
      byte_done && rx_ok |=> drv_ff && state_ff == emx_pkg::ST_ACK;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("received byte not acknowledged");

  property p_busy_noack;
    @(negedge scl_clk_in) disable iff (init_s)
      rx_state && busy_s |=> !drv_ff;
  endproperty
  a_busy_noack: assert property (p_busy_noack)
    else $error("acknowledge given during programming");

  property p_ack_width;
    @(negedge scl_clk_in) disable iff (init_s)
      state_ff == emx_pkg::ST_ACK && rw_ff != emx_pkg::RW_READ &&
      !cond_any |-> drv_ff ##1 !drv_ff;
  endproperty
  a_ack_width: assert property (p_ack_width)
    else $error("acknowledge not held for exactly one clock");

  property p_nack_release;
    @(negedge scl_clk_in) disable iff (init_s)
      state_ff == emx_pkg::ST_RACK && samp_ff != emx_pkg::ACK_LVL &&
      !cond_any |=> !drv_ff && state_ff == emx_pkg::ST_IDLE;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data not released after no-acknowledge");

  property p_read_select;
    @(negedge scl_clk_in) disable iff (init_s)
      byte_done && rx_ok && state_ff == emx_pkg::ST_ADDR &&
      samp_ff == emx_pkg::RW_READ && !busy_s
      |=> ##1 state_ff == emx_pkg::ST_RDATA || cond_any;
  endproperty
  a_read_select: assert property (p_read_select)
    else $error("read bit did not select transmit");

  property p_read_step;
    @(negedge scl_clk_in) disable iff (init_s)
      rd_done |=> ptr_ff == $past(ptr_ff) + emx_pkg::PTR_STEP;
  endproperty
  a_read_step: assert property (p_read_step)
    else $error("pointer did not step after read byte");

  property p_msb_first;
    @(negedge scl_clk_in) disable iff (init_s)
      ld_tx |=> drv_ff == !$past(mem_rd[emx_pkg::MSB]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first bit out is not the top bit");

  property p_addr_load;
    @(negedge scl_clk_in) disable iff (init_s)
      byte_done && rx_ok && state_ff == emx_pkg::ST_WADDR
      |=> ptr_ff == $past(rx_byte[emx_pkg::MEM_AW-1:0]);
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("word address not loaded into pointer");

endmodule // emx_eeprom_slave
`default_nettype wire

// ### core/emx_pkg.sv
// shared constants and types of the eeprom two-wire slave
package emx_pkg;

  // memory geometry; depth kept small and plain
  localparam int unsigned MEM_AW    = 4;
  localparam int unsigned MEM_DEPTH = 16;
  localparam int unsigned BYTE_W    = 8;

  // byte framing
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_STEP  = 3'h1;
  localparam int unsigned MSB      = 7;

  // control byte: slave address and direction bit
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic       RW_READ  = 1'h1;
  localparam logic       ACK_LVL  = 1'h0;

  // word pointer
  localparam logic [MEM_AW-1:0] PTR_STEP = 4'h1;
  localparam logic [MEM_AW-1:0] PTR_INIT = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ACK   = 3'h3,
    ST_WADDR = 3'h2,
    ST_WDATA = 3'h6,
    ST_RDATA = 3'h7,
    ST_RACK  = 3'h5
  } emx_state_e;

  typedef enum logic {
    PH_WADDR = 1'h0,
    PH_WDATA = 1'h1
  } emx_phase_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } emx_line_s;

endpackage

// ### core/emx_sync.sv
// two-flop level synchroniser of configurable width
`timescale 1ns/10ps
`default_nettype none
module emx_sync #(
  parameter int unsigned W = 1
) (
  // clock
  input  wire logic         clk_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  // pure data pipe: no reset, settles within two edges
  always_ff @(posedge clk_in) begin
    meta_ff <= d_in;
    hold_ff <= meta_ff;
  end

  assign q_out = hold_ff;

endmodule // emx_sync
`default_nettype wire

// ### core/emx_cond_det.sv
// reference-clock stop detector and bus idle tracker
`timescale 1ns/10ps
`default_nettype none
module emx_cond_det (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  // synchronised bus lines
  input  wire emx_pkg::emx_line_s line_in,
  // status
  output logic                   link_idle_out,
  output logic                   stop_pulse_out
);

  emx_pkg::emx_line_s prev_ff;
  logic               stop_seen;

  always_ff @(posedge ref_clk_in) begin
    prev_ff <= line_in;
  end

  assign stop_seen = prev_ff.scl & line_in.scl & ~prev_ff.sda & line_in.sda;

  // idle from stop until the clock line next goes low
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      link_idle_out <= 1'h1;
    end else if (stop_seen) begin
      link_idle_out <= 1'h1;
    end else if (!line_in.scl) begin
      link_idle_out <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      stop_pulse_out <= 1'h0;
    end else begin
      stop_pulse_out <= stop_seen;
    end
  end

endmodule // emx_cond_det
`default_nettype wire

// ### testbench/emx_tb_master.sv
// two-wire bus master model: open-drain data, clock only within frames
`timescale 1ns/10ps
`default_nettype none
module emx_tb_master (
  // bus lines
  output logic     scl_out,
  output logic     sda_low_out,
  input  wire logic sda_in
);
  // clock rests high, data released: bus idle
  initial begin
    scl_out     = 1'h1;
    sda_low_out = 1'h0;
  end

  task automatic start();
    sda_low_out = 1'h0;
    #20 scl_out = 1'h1;
    #40 sda_low_out = 1'h1;
    #40 scl_out = 1'h0;
  endtask

  task automatic stop();
    sda_low_out = 1'h1;
    #20 scl_out = 1'h1;
    #40 sda_low_out = 1'h0;
    #40;
  endtask

  // data moves only while clock low; held clears on a change while high
  task automatic bit_xfer(input logic drv, output logic seen, output logic held);
    #20 sda_low_out = ~drv;
    #20 scl_out = 1'h1;
    #5 seen = sda_in;
    held = 1'h1;
    repeat (6) begin
      #5 held = held & (sda_in == seen);
    end
    #5 scl_out = 1'h0;
  endtask

  // msb first, ninth clock must see a steady low
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    logic h;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], s, h);
    bit_xfer(1'h1, s, h);
    ack = ~s & h;
  endtask

  // acknowledge all but the last byte; unsteady bit reads unknown
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic s;
    logic h;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'h1, s, h);
      b[i] = h ? s : 1'hx;
    end
    bit_xfer(~more, s, h);
  endtask
endmodule // emx_tb_master
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench of the eeprom two-wire slave
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk_in;
  logic rst_n_in;
  logic prog_busy_in;
  logic scl;
  logic m_low;
  logic sda;
  logic sda_dout;
  logic sda_oe;
  logic bus_busy;
  logic stop_pulse;
  logic wr_pulse;
  int   n_errors  = 0;
  int   tests_run = 0;
  int   n_wr      = 0;
  int   n_stop    = 0;
  int   cyc       = 0;
  // contents at addresses 0E, 0F, 00, 01
  localparam logic [7:0] PAT [4] = '{8'h5A, 8'hC3, 8'h96, 8'h3C};
  localparam logic [7:0] CW = {emx_pkg::DEV_ADDR, 1'h0};
  localparam logic [7:0] CR = {emx_pkg::DEV_ADDR, emx_pkg::RW_READ};

  // pull-up: released line reads high
  assign sda = ~(m_low | (sda_oe & ~sda_dout));

  emx_tb_master mst (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));

  emx_eeprom_slave dut (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .scl_clk_in    (scl),
    .sda_in        (sda),
    .sda_dout_out  (sda_dout),
    .sda_oe_out    (sda_oe),
    .prog_busy_in  (prog_busy_in),
    .bus_busy_out  (bus_busy),
    .stop_pulse_out(stop_pulse),
    .wr_pulse_out  (wr_pulse)
  );

  initial begin
    ref_clk_in = 1'h0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // pulse counters and hang guard
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    n_wr <= n_wr + int'(wr_pulse === 1'h1);
    n_stop <= n_stop + int'(stop_pulse === 1'h1);
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask

  // start plus control byte, acknowledge expected or not
  task automatic open_ctrl(input logic [7:0] c, input logic exp_ack);
    logic a;
    mst.start();
    mst.wr_byte(c, a);
    check("ctrl ack", 8'(a), 8'(exp_ack));
  endtask

  // set the word pointer inside a write, left open for a repeated start
  task automatic load_ptr(input logic [7:0] w);
    logic a;
    open_ctrl(CW, 1'h1);
    mst.wr_byte(w, a);
    check("waddr ack", 8'(a), 8'h01);
  endtask

  // read n bytes from pattern index k, then stop
  task automatic read_run(input int k, input int n);
    logic [7:0] b;
    open_ctrl(CR, 1'h1);
    for (int i = 0; i < n; i++) begin
      mst.rd_byte(i < n - 1, b);
      check("read data", b, PAT[(k + i) % 4]);
    end
    // let the falling edge that ends the nack bit take effect
    #2;
    check("release after nack", 8'(sda_oe), 8'h00);
    mst.stop();
    settle(8);
  endtask

  task automatic t_write();
    logic a;
    int   w0;
    int   s0;
    w0 = n_wr;
    s0 = n_stop;
    load_ptr(8'h0E);
    check("busy in frame", 8'(bus_busy), 8'h01);
    for (int i = 0; i < 4; i++) begin
      mst.wr_byte(PAT[i], a);
      check("data ack", 8'(a), 8'h01);
    end
    mst.stop();
    settle(8);
    check("array writes", 8'(n_wr - w0), 8'h04);
    check("stop pulses", 8'(n_stop - s0), 8'h01);
    check("busy after stop", 8'(bus_busy), 8'h00);
    check("idle no pull", 8'(sda_oe), 8'h00);
    $display("test write done");
  endtask

  task automatic t_random();
    load_ptr(8'h0E);
    read_run(0, 1);
    $display("test random read done");
  endtask

  task automatic t_current();
    // pointer sits past the word just read
    read_run(1, 1);
    $display("test current read done");
  endtask

  task automatic t_sequential();
    load_ptr(8'h0F);
    // stream across the top of memory
    read_run(1, 3);
    $display("test sequential read done");
  endtask

  task automatic t_wrong_addr();
    logic a;
    open_ctrl(CW ^ 8'h02, 1'h0);
    mst.wr_byte(8'h00, a);
    check("unaddressed ack", 8'(a), 8'h00);
    mst.stop();
    settle(8);
    check("idle no pull", 8'(sda_oe), 8'h00);
    $display("test wrong address done");
  endtask

  task automatic t_prog_busy();
    logic a;
    int   w0;
    w0 = n_wr;
    prog_busy_in = 1'h1;
    open_ctrl(CW, 1'h0);
    mst.wr_byte(8'h0E, a);
    check("busy ack", 8'(a), 8'h00);
    mst.wr_byte(8'hFF, a);
    check("busy data ack", 8'(a), 8'h00);
    mst.stop();
    settle(8);
    check("busy writes", 8'(n_wr - w0), 8'h00);
    prog_busy_in = 1'h0;
    // array untouched: pointer reload reads old word
    load_ptr(8'h0E);
    read_run(0, 1);
    $display("test programming busy done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n_in = 1'h0;
    prog_busy_in = 1'h0;
    repeat (16) @(posedge ref_clk_in);
    #2 rst_n_in = 1'h1;
    settle(10);
    // offset link edges from the reference grid
    #7;
    t_write();
    t_random();
    t_current();
    t_sequential();
    t_wrong_addr();
    t_prog_busy();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
